/* verilog/fcd_pkg.sv */
// Constants, layouts and state codes of the four-channel DMA engine
package fcd_pkg;
   localparam int NCH = 4;
   // Register offsets inside one channel window
   localparam logic [4:0] OFS_SRC = 5'h00;
   localparam logic [4:0] OFS_DST = 5'h04;
   localparam logic [4:0] OFS_CNT = 5'h08;
   localparam logic [4:0] OFS_CTL = 5'h0C;
   localparam logic [4:0] OFS_STS = 5'h10;
   localparam logic [4:0] OFS_VEC = 5'h14;
   // The two address bits above the offset select the channel
   localparam int CH_LSB = 5;
   localparam int MAP_MSB = 7;
   // channel_control fields
   localparam int CTL_START = 0;
   localparam int CTL_EXT = 1;
   localparam int CTL_CS = 2;
   localparam int CTL_SAA = 3;
   localparam int CTL_SRC_INCR = 4;
   localparam int CTL_DST_INCR = 5;
   localparam int CTL_SW = 6;
   localparam int CTL_DW = 8;
   localparam int CTL_BWC = 10;
   localparam int CTL_INT = 13;
   localparam int CTL_SRW = 14;
   localparam int CTL_AT = 15;
   localparam logic [15:0] CTL_RST = 16'h0000;
   // Status fields
   localparam int STS_DONE = 0;
   localparam int STS_BSY = 1;
   localparam int STS_REQ = 2;
   localparam int STS_BED = 4;
   localparam int STS_BES = 5;
   localparam int STS_CE = 6;
   localparam logic [6:0] STS_RST = 7'h00;
   localparam logic [7:0] VEC_RST = 8'h0F;
   // Width codes
   localparam logic [1:0] W_LONG = 2'h0;
   localparam logic [1:0] W_BYTE = 2'h1;
   localparam logic [1:0] W_WORD = 2'h2;
   localparam logic [1:0] W_LINE = 2'h3;
   // Nonzero bandwidth code k gives a block of 2**(k+BW_LOG_OFS) bytes; code 0 sets no block limit
   localparam int BW_LOG_OFS = 3;
   // Least clocks from a sampled request pin to a bus cycle
   localparam int REQ_MIN_CLK = 4;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ARB = 3'h1,
      ST_WAITG = 3'h3,
      ST_ISSUE = 3'h2,
      ST_BUSY = 3'h6
   } fcd_state_t;
endpackage

/* verilog/fcd_dma.sv */
// Four-channel DMA transfer engine with its register file
`timescale 1ns/100ps
module fcd_dma
   import fcd_pkg::*;
#(
   parameter int AW = 32,
   parameter int CW = 24
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [1:0] ext_dma_ask_n,
   input wire logic [1:0] serial_irq,
   output logic bus_req,
   input wire logic bus_grant,
   output logic transfer_start_n,
   output logic [AW-1:0] bus_addr,
   output logic bus_read,
   output logic [1:0] bus_width,
   output logic [31:0] bus_wdata,
   input wire logic [31:0] bus_rdata,
   input wire logic bus_done,
   input wire logic bus_err,
   output logic transfer_modifier,
   output logic [3:0] dma_irq,
   input wire logic iack,
   input wire logic [1:0] iack_ch,
   output logic [7:0] iack_vector
);
   if (AW < 5 || AW > 32 || CW < 11 || CW > 32)
   begin : g_bad
      $error("fcd_dma: AW or CW out of range");
   end

   function automatic logic [4:0] wbytes(input logic [1:0] w);
      unique case (w)
         W_LONG: return 5'h04;
         W_BYTE: return 5'h01;
         W_WORD: return 5'h02;
         W_LINE: return 5'h10;
      endcase
   endfunction

   function automatic logic [4:0] beat(input logic [4:0] b);
      return (b > 5'h04) ? 5'h04 : b;
   endfunction

   function automatic logic bad(input logic [4:0] a, input logic [4:0] b);
      return (a & (b - 5'h01)) != 5'h00;
   endfunction

   function automatic logic [3:0] pkey(input int i, input logic [2:0] b,
                                       input logic [2:0] bp);
      if (i > 0 && b == 3'h0 && bp != 3'h0)
         return 4'(2 * i - 1);
      return 4'(2 * i + 2);
   endfunction

   fcd_state_t state_r;
   logic [1:0] ch_r;
   logic wr_ph_r;
   logic [4:0] rem_r;
   logic [3:0] rp_r;
   logic [3:0] wp_r;
   logic [7:0] hold_r [16];
   logic [15:0] ctl_r [NCH];
   logic [AW-1:0] src_r [NCH];
   logic [AW-1:0] dst_r [NCH];
   logic [CW-1:0] cnt_r [NCH];
   logic [6:0] sts_r [NCH];
   logic [7:0] vec_r [NCH];
   logic [NCH-1:0] ask_r;
   logic [NCH-1:0] pend_r;
   logic [NCH-1:0] reqv;
   logic [1:0] win;
   logic [15:0] cc;
   logic single_addr_sel;
   logic [4:0] sb;
   logic [4:0] db;
   logic [4:0] tb;
   logic [4:0] sbt;
   logic [4:0] dbt;
   logic [CW-1:0] nb;
   logic cfg_bad;
   logic last;
   logic boundary;
   logic sel_hit;
   logic done_wr;

   assign cc = ctl_r[ch_r];
   assign single_addr_sel = cc[CTL_SAA];
   assign sb = wbytes(cc[CTL_SW+:2]);
   assign db = wbytes(cc[CTL_DW+:2]);
   assign tb = (single_addr_sel || sb > db) ? sb : db;
   assign sbt = beat(sb);
   assign dbt = beat(db);
   assign nb = cnt_r[ch_r] - CW'(tb);
   assign last = rem_r == (wr_ph_r ? dbt : sbt);
   assign sel_hit = reg_wr && !reg_addr[MAP_MSB] &&
                    reg_addr[4:0] == OFS_STS && reg_wdata[STS_DONE];
   assign done_wr = sel_hit && reg_addr[CH_LSB+:2] == ch_r;
   assign cfg_bad = cnt_r[ch_r] == '0 || bad(src_r[ch_r][4:0], sb) ||
                    bad(cnt_r[ch_r][4:0], tb) ||
                    (!single_addr_sel && bad(dst_r[ch_r][4:0], db));

   always_comb
   begin
      boundary = 1'b0;
      if (cc[CTL_BWC+:3] != 3'h0)
         boundary = (nb & ((CW'(1) << (cc[CTL_BWC+:3] + BW_LOG_OFS))
                    - CW'(1))) == '0;
   end

   // Requests are ignored while the done or error flag still stands
   always_comb
   begin
      logic [3:0] best;
      best = 4'hF;
      win = 2'h0;
      reqv = '0;
      for (int i = 0; i < NCH; i++)
      begin
         reqv[i] = (pend_r[i] || ctl_r[i][CTL_START]) &&
                   sts_r[i][STS_DONE] == 1'b0 &&
                   sts_r[i][STS_CE] == 1'b0;
         if (reqv[i] && pkey(i, ctl_r[i][CTL_BWC+:3],
             ctl_r[(i + NCH - 1) % NCH][CTL_BWC+:3]) < best)
         begin
            best = pkey(i, ctl_r[i][CTL_BWC+:3],
                        ctl_r[(i + NCH - 1) % NCH][CTL_BWC+:3]);
            win = 2'(i);
         end
      end
   end

   // Single sampled edge is enough to hold a request
   always_ff @(posedge clk)
   begin
      if (srst)
         ask_r <= '0;
      else
         ask_r <= {serial_irq, ~ext_dma_ask_n};
   end

   // Engine and channel registers; later assignments override earlier
   // ones so hardware sets win over software clears in the same cycle
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_r <= ST_IDLE;
         ch_r <= 2'h0;
         wr_ph_r <= 1'b0;
         rem_r <= 5'h00;
         rp_r <= 4'h0;
         wp_r <= 4'h0;
         bus_req <= 1'b0;
         pend_r <= '0;
         for (int i = 0; i < NCH; i++)
         begin
            ctl_r[i] <= CTL_RST;
            src_r[i] <= '0;
            dst_r[i] <= '0;
            cnt_r[i] <= '0;
            sts_r[i] <= STS_RST;
            vec_r[i] <= VEC_RST;
         end
         for (int k = 0; k < 16; k++)
            hold_r[k] <= 8'h00;
      end
      else
      begin
         for (int i = 0; i < NCH; i++)
         begin
            if (reg_wr && !reg_addr[MAP_MSB] && reg_addr[CH_LSB+:2] == 2'(i))
            begin
               unique case (reg_addr[4:0])
                  OFS_SRC: src_r[i] <= reg_wdata[AW-1:0];
                  OFS_DST: dst_r[i] <= reg_wdata[AW-1:0];
                  OFS_CNT: cnt_r[i] <= reg_wdata[CW-1:0];
                  OFS_CTL: ctl_r[i] <= reg_wdata[15:0];
                  OFS_VEC: vec_r[i] <= reg_wdata[7:0];
                  OFS_STS:
                     if (reg_wdata[STS_DONE])
                     begin
                        sts_r[i] <= STS_RST;
                        pend_r[i] <= 1'b0;
                     end
                  default: ;
               endcase
            end
         end
         unique case (state_r)
            ST_IDLE:
               if (reqv != '0)
               begin
                  ch_r <= win;
                  state_r <= ST_ARB;
               end
            ST_ARB:
            begin
               wr_ph_r <= 1'b0;
               rem_r <= single_addr_sel ? sbt : tb;
               rp_r <= 4'h0;
               wp_r <= 4'h0;
               if (cfg_bad)
               begin
                  sts_r[ch_r][STS_CE] <= 1'b1;
                  pend_r[ch_r] <= 1'b0;
                  ctl_r[ch_r][CTL_START] <= 1'b0;
                  state_r <= ST_IDLE;
               end
               else
               begin
                  sts_r[ch_r][STS_REQ] <= 1'b1;
                  bus_req <= 1'b1;
                  state_r <= ST_WAITG;
               end
            end
            ST_WAITG:
            begin
               bus_req <= 1'b1;
               if (bus_grant && bus_req)
               begin
                  sts_r[ch_r][STS_BSY] <= 1'b1;
                  sts_r[ch_r][STS_REQ] <= 1'b0;
                  state_r <= ST_ISSUE;
               end
            end
            ST_ISSUE:
            begin
               ctl_r[ch_r][CTL_START] <= 1'b0;
               if (wr_ph_r || single_addr_sel)
                  pend_r[ch_r] <= 1'b0;
               state_r <= ST_BUSY;
            end
            ST_BUSY:
               if (bus_done && transfer_start_n)
               begin
                  if (bus_err)
                  begin
                     if (wr_ph_r)
                        sts_r[ch_r][STS_BED] <= 1'b1;
                     else
                        sts_r[ch_r][STS_BES] <= 1'b1;
                     sts_r[ch_r][STS_DONE] <= 1'b1;
                     sts_r[ch_r][STS_BSY] <= 1'b0;
                     pend_r[ch_r] <= 1'b0;
                     bus_req <= 1'b0;
                     state_r <= ST_IDLE;
                  end
                  else if (!wr_ph_r)
                  begin
                     if (cc[CTL_SRC_INCR])
                        src_r[ch_r] <= src_r[ch_r] + AW'(sbt);
                     for (int k = 0; k < 4; k++)
                        if (5'(k) < sbt && !single_addr_sel)
                           hold_r[4'(rp_r + 4'(k))] <= bus_rdata[8*k+:8];
                     rp_r <= rp_r + sbt[3:0];
                     rem_r <= rem_r - sbt;
                     state_r <= ST_ISSUE;
                     if (last && !single_addr_sel)
                     begin
                        wr_ph_r <= 1'b1;
                        rem_r <= tb;
                     end
                  end
                  else
                  begin
                     if (cc[CTL_DST_INCR])
                        dst_r[ch_r] <= dst_r[ch_r] + AW'(dbt);
                     wp_r <= wp_r + dbt[3:0];
                     rem_r <= rem_r - dbt;
                     state_r <= ST_ISSUE;
                  end
                  if (!bus_err && last && (wr_ph_r || single_addr_sel))
                  begin
                     cnt_r[ch_r] <= nb;
                     wr_ph_r <= 1'b0;
                     rem_r <= single_addr_sel ? sbt : tb;
                     rp_r <= 4'h0;
                     wp_r <= 4'h0;
                     if (nb == '0)
                     begin
                        sts_r[ch_r][STS_DONE] <= 1'b1;
                        sts_r[ch_r][STS_BSY] <= 1'b0;
                        pend_r[ch_r] <= 1'b0;
                        bus_req <= 1'b0;
                        state_r <= ST_IDLE;
                     end
                     else if (cc[CTL_CS])
                     begin
                        bus_req <= 1'b0;
                        state_r <= ST_IDLE;
                     end
                     else if (boundary)
                     begin
                        bus_req <= 1'b0;
                        state_r <= ST_WAITG;
                     end
                  end
               end
            default:
               state_r <= ST_IDLE;
         endcase
         // A done write stops the channel; a bus cycle in flight is
         // left to end on its own
         if (done_wr && state_r != ST_IDLE)
         begin
            bus_req <= 1'b0;
            state_r <= ST_IDLE;
         end
         for (int i = 0; i < NCH; i++)
            if (ask_r[i] && ctl_r[i][CTL_EXT])
               pend_r[i] <= 1'b1;
      end
   end

   // Bus pins and acknowledge, all registered
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         transfer_start_n <= 1'b1;
         bus_addr <= '0;
         bus_read <= 1'b1;
         bus_width <= W_LONG;
         bus_wdata <= 32'h0000_0000;
         transfer_modifier <= 1'b0;
      end
      else
      begin
         transfer_start_n <= state_r != ST_ISSUE;
         if (state_r == ST_ISSUE)
         begin
            bus_addr <= wr_ph_r ? dst_r[ch_r] : src_r[ch_r];
            bus_read <= single_addr_sel ? cc[CTL_SRW] : !wr_ph_r;
            bus_width <= wr_ph_r ? (db > 5'h04 ? W_LONG : cc[CTL_DW+:2])
                                 : (sb > 5'h04 ? W_LONG : cc[CTL_SW+:2]);
            for (int k = 0; k < 4; k++)
               bus_wdata[8*k+:8] <= (wr_ph_r && 5'(k) < dbt) ?
                                    hold_r[4'(wp_r + 4'(k))] : 8'h00;
            transfer_modifier <= !cc[CTL_AT] ||
                                 cnt_r[ch_r] == CW'(tb);
         end
         else if (state_r != ST_BUSY)
            transfer_modifier <= 1'b0;
      end
   end

   // Read port, interrupt lines and vector answer
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         reg_rdata <= 32'h0000_0000;
         dma_irq <= 4'h0;
         iack_vector <= 8'h00;
      end
      else
      begin
         reg_rdata <= 32'h0000_0000;
         if (reg_rd && !reg_addr[MAP_MSB])
         begin
            unique case (reg_addr[4:0])
               OFS_SRC: reg_rdata <= 32'(src_r[reg_addr[CH_LSB+:2]]);
               OFS_DST: reg_rdata <= 32'(dst_r[reg_addr[CH_LSB+:2]]);
               OFS_CNT: reg_rdata <= 32'(cnt_r[reg_addr[CH_LSB+:2]]);
               OFS_CTL: reg_rdata <= 32'(ctl_r[reg_addr[CH_LSB+:2]]);
               OFS_STS: reg_rdata <= 32'(sts_r[reg_addr[CH_LSB+:2]]);
               OFS_VEC: reg_rdata <= 32'(vec_r[reg_addr[CH_LSB+:2]]);
               default: ;
            endcase
         end
         for (int i = 0; i < NCH; i++)
            dma_irq[i] <= ctl_r[i][CTL_INT] && (sts_r[i][STS_DONE] ||
                          sts_r[i][STS_CE]);
         iack_vector <= iack ? vec_r[iack_ch] : 8'h00;
      end
   end

   sequence s_newreq;
      state_r == ST_IDLE && reqv == '0 ##1 reqv != '0;
   endsequence

   sequence s_release;
      !bus_req ##1 bus_req;
   endsequence

   a_start_clear: assert property (@(posedge clk) disable iff (srst)
      state_r == ST_ISSUE && !done_wr |=> !ctl_r[$past(ch_r)][CTL_START])
      else $error("start bit not cleared at access");
   a_cfg_error: assert property (@(posedge clk) disable iff (srst)
      state_r == ST_ARB && cfg_bad |=> state_r == ST_IDLE &&
      sts_r[$past(ch_r)][STS_CE] ##1 transfer_start_n)
      else $error("bad setup not refused");
   a_count_step: assert property (@(posedge clk) disable iff (srst)
      state_r == ST_BUSY && bus_done && transfer_start_n && !bus_err &&
      last && (wr_ph_r || single_addr_sel) |=>
      cnt_r[$past(ch_r)] == $past(cnt_r[ch_r]) - CW'($past(tb)))
      else $error("byte count step wrong");
   a_pin_latency: assert property (@(posedge clk) disable iff (srst)
      s_newreq |-> transfer_start_n [*3])
      else $error("bus cycle too soon after request");
   a_bw_release: assert property (@(posedge clk) disable iff (srst)
      state_r == ST_BUSY && bus_done && transfer_start_n && !bus_err &&
      last && (wr_ph_r || single_addr_sel) && nb != '0 && !cc[CTL_CS] && boundary &&
      !done_wr |=> s_release)
      else $error("bus request not released at boundary");
   a_err_stop: assert property (@(posedge clk) disable iff (srst)
      state_r == ST_BUSY && bus_done && transfer_start_n && bus_err |=>
      state_r == ST_IDLE && sts_r[$past(ch_r)][STS_DONE] && !bus_req)
      else $error("bus error did not stop channel");
   a_steal_once: assert property (@(posedge clk) disable iff (srst)
      state_r == ST_BUSY && bus_done && transfer_start_n && !bus_err &&
      last && (wr_ph_r || single_addr_sel) && cc[CTL_CS] |=> state_r == ST_IDLE)
      else $error("cycle steal ran on");
   a_ack_final: assert property (@(posedge clk) disable iff (srst)
      $fell(transfer_start_n) && $past(cc[CTL_AT]) &&
      $past(cnt_r[ch_r]) != CW'($past(tb)) |-> !transfer_modifier)
      else $error("acknowledge outside final transfer");
   a_vec_answer: assert property (@(posedge clk) disable iff (srst)
      iack |=> iack_vector == $past(vec_r[iack_ch]))
      else $error("vector answer wrong");
endmodule // fcd_dma

/* tb/fcd_bus_model.sv */
// Arbiter and memory slave that answers the engine's bus accesses
`timescale 1ns/100ps
module fcd_bus_model
(
   input wire logic clk,
   input wire logic srst,
   input wire logic bus_req,
   input wire logic transfer_start_n,
   input wire logic bus_read,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic transfer_modifier,
   input wire logic [3:0] lat,
   input wire logic err_mode,
   output logic bus_grant,
   output logic bus_done,
   output logic bus_err,
   output logic [31:0] bus_rdata,
   output int acc_cnt,
   output int rd_cnt,
   output int tm_cnt,
   output int drop_cnt,
   output logic [31:0] last_wdata
);
   logic [3:0] wait_r;
   logic busy_r;
   logic req_d_r;
   // Grant follows request one cycle late, so a dropped request loses it
   always_ff @(posedge clk)
   begin
      bus_grant <= bus_req & ~srst;
      req_d_r <= bus_req;
      if (req_d_r & ~bus_req)
         drop_cnt <= drop_cnt + 1;
   end
   // Data lines toggle outside the done cycle, never hold stale data
   always_ff @(posedge clk)
   begin
      bus_done <= 1'b0;
      bus_err <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (srst)
      begin
         busy_r <= 1'b0;
         wait_r <= 4'h0;
         bus_rdata <= 32'h0;
      end
      else if (!transfer_start_n)
      begin
         busy_r <= 1'b1;
         wait_r <= lat;
         acc_cnt <= acc_cnt + 1;
         rd_cnt <= rd_cnt + int'(bus_read);
         tm_cnt <= tm_cnt + int'(transfer_modifier);
         if (!bus_read)
            last_wdata <= bus_wdata;
      end
      else if (busy_r)
      begin
         if (wait_r <= 4'h1)
         begin
            busy_r <= 1'b0;
            bus_done <= 1'b1;
            bus_err <= err_mode;
            bus_rdata <= {4{bus_addr[7:0]}};
         end
         else
            wait_r <= wait_r - 4'h1;
      end
   end
endmodule // fcd_bus_model

/* tb/testbench.sv */
// Self-checking bench for the four-channel DMA engine
`timescale 1ns/100ps
module testbench;
   import fcd_pkg::*;
   localparam logic [31:0] S = 32'h1 << CTL_START;
   localparam logic [31:0] EX = 32'h1 << CTL_EXT;
   localparam logic [31:0] CS = 32'h1 << CTL_CS;
   localparam logic [31:0] SA = 32'h1 << CTL_SAA;
   localparam logic [31:0] SI = 32'h1 << CTL_SRC_INCR;
   localparam logic [31:0] DI = 32'h1 << CTL_DST_INCR;
   localparam logic [31:0] IE = 32'h1 << CTL_INT;
   localparam logic [31:0] RW = 32'h1 << CTL_SRW;
   localparam logic [31:0] AT = 32'h1 << CTL_AT;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [1:0] ext_dma_ask_n = 2'h3;
   logic [1:0] serial_irq = 2'h0;
   logic bus_req, bus_grant, transfer_start_n, bus_read, bus_done, bus_err;
   logic [31:0] bus_addr, bus_wdata, bus_rdata, last_wdata;
   logic [1:0] bus_width;
   logic transfer_modifier;
   logic [3:0] dma_irq;
   logic iack = 1'b0;
   logic [1:0] iack_ch = 2'h0;
   logic [7:0] iack_vector;
   logic [3:0] lat = 4'h1;
   logic err_mode = 1'b0;
   int acc_cnt, rd_cnt, tm_cnt, drop_cnt;
   int error_cnt = 0;
   int comparisons = 0;
   always #10 clk = ~clk;
   fcd_dma #(.AW(32), .CW(24)) i_fcd_dma (.clk(clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_dma_ask_n(ext_dma_ask_n),
      .serial_irq(serial_irq), .bus_req(bus_req), .bus_grant(bus_grant),
      .transfer_start_n(transfer_start_n), .bus_addr(bus_addr),
      .bus_read(bus_read), .bus_width(bus_width), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .bus_done(bus_done), .bus_err(bus_err),
      .transfer_modifier(transfer_modifier), .dma_irq(dma_irq),
      .iack(iack), .iack_ch(iack_ch), .iack_vector(iack_vector));
   fcd_bus_model i_fcd_bus_model (.clk(clk), .srst(srst), .bus_req(bus_req),
      .transfer_start_n(transfer_start_n), .bus_read(bus_read),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .transfer_modifier(transfer_modifier), .lat(lat),
      .err_mode(err_mode), .bus_grant(bus_grant), .bus_done(bus_done),
      .bus_err(bus_err), .bus_rdata(bus_rdata), .acc_cnt(acc_cnt),
      .rd_cnt(rd_cnt), .tm_cnt(tm_cnt), .drop_cnt(drop_cnt),
      .last_wdata(last_wdata));
   task automatic end_of_test();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [7:0] ra(input int ch, input logic [4:0] ofs);
      return {1'b0, ch[1:0], ofs};
   endfunction
   function automatic logic [31:0] wd(input logic [1:0] s, input logic [1:0] d);
      return (32'(s) << CTL_SW) | (32'(d) << CTL_DW);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      check(nm, v, exp);
   endtask
   // Status is cleared before any start
   task automatic prog(input int ch, input logic [31:0] c,
                       input logic [31:0] ctl);
      wr(ra(ch, OFS_STS), 32'h1);
      wr(ra(ch, OFS_SRC), 32'h100);
      wr(ra(ch, OFS_DST), 32'h200);
      wr(ra(ch, OFS_CNT), c);
      wr(ra(ch, OFS_CTL), ctl);
   endtask
   task automatic wait_done(input int ch);
      logic [31:0] v;
      v = 32'h0;
      for (int i = 0; i < 300 && v[STS_DONE] !== 1'b1; i++)
         rd(ra(ch, OFS_STS), v);
   endtask
   // Software-started block; counts, addresses and bus traffic judged
   task automatic xfer(input int ch, input logic [31:0] ctl, input int c,
      input int ea, input int er, input int et, input int ed,
      input logic [31:0] es, input logic [31:0] edst);
      int a0, r0, t0, d0;
      logic [31:0] v;
      a0 = acc_cnt;
      r0 = rd_cnt;
      t0 = tm_cnt;
      d0 = drop_cnt;
      prog(ch, c, ctl | S);
      wait_done(ch);
      rdchk("status", ra(ch, OFS_STS), 32'h1);
      rdchk("count", ra(ch, OFS_CNT), 32'h0);
      rdchk("src", ra(ch, OFS_SRC), es);
      rdchk("dst", ra(ch, OFS_DST), edst);
      rd(ra(ch, OFS_CTL), v);
      check("start", v[CTL_START], 1'b0);
      check("accesses", acc_cnt - a0, ea);
      check("reads", rd_cnt - r0, er);
      check("acks", tm_cnt - t0, et);
      check("drops", drop_cnt - d0, ed);
   endtask
   task automatic ask(input int ch, input logic on);
      if (ch < 2)
         ext_dma_ask_n[ch] <= ~on;
      else
         serial_irq[ch-2] <= on;
   endtask
   // Pin or serial request, cycle-steal: one transfer per request
   task automatic t_ext(input int ch);
      int a0, n;
      prog(ch, 4, CS | SI | DI | wd(W_BYTE, W_BYTE));
      a0 = acc_cnt;
      @(posedge clk);
      ask(ch, 1'b1);
      @(posedge clk);
      ask(ch, 1'b0);
      repeat (20) @(posedge clk);
      check("no_ext", acc_cnt - a0, 0);
      prog(ch, 4, EX | CS | SI | DI | wd(W_BYTE, W_BYTE));
      @(posedge clk);
      ask(ch, 1'b1);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (transfer_start_n !== 1'b0 && n < 60);
      ask(ch, 1'b0);
      check("latency", n > REQ_MIN_CLK + 1, 1'b1);
      repeat (40) @(posedge clk);
      check("steal", acc_cnt - a0, 2);
      rdchk("cnt_left", ra(ch, OFS_CNT), 32'h3);
   endtask
   task automatic t_cfg();
      int a0;
      a0 = acc_cnt;
      prog(0, 0, S | SI | DI | wd(W_BYTE, W_BYTE));
      // Error flag lands two edges after the start write
      repeat (2) @(posedge clk);
      rdchk("zero_cnt", ra(0, OFS_STS), 32'h40);
      prog(1, 2, IE | SI | DI | wd(W_WORD, W_WORD));
      wr(ra(1, OFS_SRC), 32'h101);
      wr(ra(1, OFS_CTL), S | IE | SI | DI | wd(W_WORD, W_WORD));
      repeat (2) @(posedge clk);
      rdchk("misalign", ra(1, OFS_STS), 32'h40);
      check("irq", dma_irq[1], 1'b1);
      check("no_bus", acc_cnt - a0, 0);
      wr(ra(1, OFS_STS), 32'h0);
      rdchk("wr_zero", ra(1, OFS_STS), 32'h40);
      wr(ra(1, OFS_STS), 32'h1);
      rdchk("cleared", ra(1, OFS_STS), 32'h0);
      check("irq_off", dma_irq[1], 1'b0);
   endtask
   task automatic t_err();
      int a0;
      err_mode <= 1'b1;
      a0 = acc_cnt;
      prog(1, 2, S | SI | DI | wd(W_BYTE, W_BYTE));
      wait_done(1);
      rdchk("bus_err", ra(1, OFS_STS), 32'h21);
      check("stopped", acc_cnt - a0, 1);
      err_mode <= 1'b0;
   endtask
   // Zero limit on channel 3 outranks channel 2 only
   task automatic t_prio();
      prog(2, 4, EX | CS | SI | (32'h1 << CTL_BWC) | wd(W_BYTE, W_BYTE));
      prog(3, 4, EX | CS | SI | wd(W_BYTE, W_BYTE));
      wr(ra(3, OFS_SRC), 32'h300);
      @(posedge clk);
      serial_irq <= 2'h3;
      @(posedge clk);
      serial_irq <= 2'h0;
      wait (transfer_start_n === 1'b0);
      #1 check("prio", bus_addr, 32'h300);
      repeat (40) @(posedge clk);
      rdchk("prio_next", ra(2, OFS_CNT), 32'h3);
   endtask
   task automatic t_misc();
      logic [31:0] v;
      rdchk("vec_rst", ra(3, OFS_VEC), 32'(VEC_RST));
      rdchk("ctl_rst", ra(2, OFS_CTL), 32'(CTL_RST));
      wr(8'h80, 32'hFFFF);
      rdchk("unmapped", 8'h80, 32'h0);
      wr(ra(2, OFS_VEC), 32'hA5);
      @(posedge clk);
      iack <= 1'b1;
      iack_ch <= 2'h2;
      @(posedge clk);
      iack <= 1'b0;
      #1 check("vector", iack_vector, 8'hA5);
      lat <= 4'h8;
      prog(3, 32, S | SI | wd(W_LONG, W_LONG));
      repeat (30) @(posedge clk);
      wr(ra(3, OFS_STS), 32'h1);
      repeat (30) @(posedge clk);
      rdchk("abort", ra(3, OFS_STS), 32'h0);
      rd(ra(3, OFS_CNT), v);
      check("abort_cnt", v != 32'h0, 1'b1);
      lat <= 4'h1;
   endtask
   initial
   begin
      #(20 * 60000);
      error_cnt++;
      end_of_test();
   end
   initial
   begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      t_misc();
      xfer(0, SI | DI | AT | wd(W_BYTE, W_BYTE), 2, 4, 2, 2, 1,
           32'h102, 32'h202);
      check("wdata", last_wdata[7:0], 8'h01);
      check("addr", bus_addr, 32'h201);
      check("width", bus_width, W_BYTE);
      xfer(1, SA | RW | SI | wd(W_BYTE, W_BYTE), 2, 2, 2, 2, 1,
           32'h102, 32'h200);
      xfer(2, SI | DI | wd(W_WORD, W_LONG), 8, 6, 4, 6, 1,
           32'h108, 32'h208);
      xfer(3, SI | AT | (32'h1 << CTL_BWC) | wd(W_LONG, W_LONG), 32, 16, 8,
           2, 2, 32'h120, 32'h200);
      xfer(3, SI | wd(W_LONG, W_LONG), 32, 16, 8, 16, 1,
           32'h120, 32'h200);
      xfer(0, SI | DI | wd(W_LINE, W_LINE), 16, 8, 4, 8, 1,
           32'h110, 32'h210);
      t_cfg();
      t_err();
      for (int ch = 0; ch < NCH; ch++)
         t_ext(ch);
      t_prio();
      end_of_test();
   end
endmodule // testbench
